// [hw/spc_pkg.sv]
package spc_pkg;

   // Byte addresses of the Wishbone register words.
   localparam logic [7:0] ADDR_SYS_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SYS_CTRL2  = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;
   localparam logic [7:0] ADDR_PIN_CTRL   = 8'h10;
   localparam logic [7:0] ADDR_CORE_STAT  = 8'h14;
   localparam logic [7:0] ADDR_GPIO_DIR   = 8'h18;

   // Field positions.
   localparam int CLK_SEL_BIT    = 14;
   localparam int BOOT_EN_BIT    = 3;
   localparam int IRQ_FAULT_A    = 0;
   localparam int IRQ_FAULT_B    = 1;
   localparam int IRQ_USER_ONE   = 2;
   localparam int IRQ_USER_TWO   = 3;
   localparam int IRQ_WDOG       = 4;
   localparam int NUM_IRQ        = 5;
   localparam int PC_POL_ONE     = 0;
   localparam int PC_POL_TWO     = 1;
   localparam int PC_CLK_GPIO    = 2;
   localparam int PC_BR_GPIO     = 3;
   localparam int PC_FAULT_A_CLR = 4;
   localparam int PC_FAULT_B_CLR = 5;

   // Reset values and counts.
   localparam logic [15:0] SYS_CTRL_RST  = 16'h0000;
   localparam logic [15:0] PROG_START    = 16'h0000;
   localparam int          WDOG_PULSE_CYC = 128;
   localparam int          GPIO_W_DEF     = 16;

   typedef struct packed {
      logic fault_a;
      logic fault_b;
      logic user_one;
      logic user_two;
   } spc_pins_t;

   typedef struct packed {
      logic [3:0] rise;
      logic [3:0] fall;
   } spc_edges_t;

   typedef enum logic [1:0] {
      RST_IDLE,
      RST_WDOG_DRIVE,
      RST_RELEASE
   } spc_rst_state_t;

endpackage

// [hw/spc_edge_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_edge_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);
   initial begin
      if (WIDTH < 1) $error("spc_edge_sync needs WIDTH of at least one");
   end

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] last_q;

   // Pins idle high, so the chain resets high to avoid a false rise at release.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '1;
         sync_q <= '1;
         last_q <= '1;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise_o = sync_q & ~last_q;
   assign fall_o = ~sync_q & last_q;
endmodule
`default_nettype wire

// [hw/spc_wdog_pulse.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_wdog_pulse #(
   parameter int CYCLES = spc_pkg::WDOG_PULSE_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   output logic      drive_o
);
   initial begin
      if (CYCLES < 2) $error("spc_wdog_pulse needs CYCLES of at least two");
   end

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   spc_pkg::spc_rst_state_t state_q;
   logic [CW-1:0]           cnt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= spc_pkg::RST_IDLE;
         cnt_q   <= '0;
         drive_o <= 1'b0;
      end else begin
         case (state_q)
            spc_pkg::RST_IDLE: begin
               if (start_i) begin
                  state_q <= spc_pkg::RST_WDOG_DRIVE;
                  cnt_q   <= '0;
                  drive_o <= 1'b1;
               end
            end
            spc_pkg::RST_WDOG_DRIVE: begin
               if (cnt_q == LAST) begin
                  state_q <= spc_pkg::RST_RELEASE;
                  drive_o <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + CW'(1);
               end
            end
            spc_pkg::RST_RELEASE: begin
               state_q <= spc_pkg::RST_IDLE;
            end
            default: begin
               state_q <= spc_pkg::RST_IDLE;
               drive_o <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [hw/spc_top.sv]
// Summary of operation
// - Reset pin low halts core and clears program counter; restart fetches at 0x0000.
// - Watchdog reset pulls reset pin low for exactly 128 input clock cycles.
// - Reset pin is open-drain: pull low or release, weak pull-up gives high.
// - Falling edge on fault input A interrupts and floats all manager A PWM pins.
// - Falling edge on fault input B interrupts and floats all manager B PWM pins.
// - Both user interrupt inputs are edge detected with software-selected polarity.
// - User interrupt two also fires the converter start trigger.
// - Clock out pin carries CPU or watchdog clock by bit 14; else GPIO.
// - Boot-enable pin level is sampled during reset into control register two bit 3.
// - After reset the boot-enable pin becomes the external flag output, driven high.
// - Conditional branch is taken when the branch-test input reads low.
// - Every reset makes the branch-test pin the branch input; software may reassign it.
// - Every GPIO pin comes out of reset as an input.
// - With test reset low, emulator pin one low and emulator pin zero high float the GPIO, boot, PWM and crystal drivers; the reset pin driver stays active.
// - With test reset high, emulator pins are scan-directed interrupt lines.
// - Crystal output floats whenever the float control is active low with test reset low and emulator pin zero high.
`timescale 1ns/1ps
`default_nettype none
module spc_top #(
   parameter int GPIO_W    = spc_pkg::GPIO_W_DEF,
   parameter int WDOG_CYC  = spc_pkg::WDOG_PULSE_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone classic slave.
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   irq_o,
   // Reset pin, open drain.
   input  wire logic              device_reset_pin_i,
   output logic                   device_reset_pin_o,
   output logic                   device_reset_pin_oe_n_o,
   input  wire logic              watchdog_reset_i,
   output logic                   core_halt_o,
   output logic      [15:0]       program_counter_o,
   output logic                   program_counter_load_o,
   // Fault and user interrupt pins.
   input  wire logic              drive_fault_in_a_i,
   input  wire logic              drive_fault_in_b_i,
   input  wire logic              user_irq_one_i,
   input  wire logic              user_irq_two_i,
   output logic                   event_manager_a_pwm_float_o,
   output logic                   event_manager_b_pwm_float_o,
   output logic                   converter_start_trigger_o,
   // Clock out pin.
   input  wire logic              cpu_clock_i,
   input  wire logic              watchdog_clock_i,
   input  wire logic              clock_gpio_out_i,
   output logic                   clock_out_pin_o,
   // Boot enable and external flag share a pin.
   input  wire logic              boot_en_pin_i,
   output logic                   external_flag_out_o,
   output logic                   boot_pin_oe_n_o,
   // Branch test.
   input  wire logic              branch_test_input_i,
   output logic                   conditional_branch_take_o,
   output logic                   branch_pin_gpio_o,
   // GPIO direction.
   output logic      [GPIO_W-1:0] gpio_oe_n_o,
   // Emulation and test.
   input  wire logic              test_reset_i,
   input  wire logic              emulator_io_zero_i,
   input  wire logic              emulator_io_one_float_i,
   input  wire logic [1:0]        emu_scan_dir_out_i,
   input  wire logic [1:0]        emu_irq_out_i,
   output logic      [1:0]        emu_pin_o,
   output logic      [1:0]        emu_pin_oe_n_o,
   output logic      [1:0]        emu_irq_in_o,
   output logic                   all_outputs_float_o,
   output logic                   crystal_out_float_o
);
   initial begin
      if (GPIO_W < 1 || GPIO_W > 32) $error("spc_top GPIO_W must be 1 to 32");
      if (WDOG_CYC < 2) $error("spc_top WDOG_CYC must be at least two");
   end

   logic [15:0]              sys_ctrl_q;
   logic [15:0]              sys_ctrl2_q;
   logic [spc_pkg::NUM_IRQ-1:0] irq_status_q;
   logic [spc_pkg::NUM_IRQ-1:0] irq_mask_q;
   logic [5:0]               pin_ctrl_q;
   logic [GPIO_W-1:0]        gpio_dir_q;
   logic                     fault_a_q;
   logic                     fault_b_q;
   logic                     out_of_reset_q;
   logic                     float_q;
   logic                     wdog_drive;
   logic                     boot_strap_q;
   logic                     pin_low;
   logic                     wb_req;
   logic                     wb_wr;
   spc_pkg::spc_pins_t       pins;
   spc_pkg::spc_edges_t      edges;
   logic [spc_pkg::NUM_IRQ-1:0] irq_event;
   logic                     ev_one;
   logic                     ev_two;

   assign pins = '{fault_a: drive_fault_in_a_i, fault_b: drive_fault_in_b_i,
                   user_one: user_irq_one_i, user_two: user_irq_two_i};

   spc_edge_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (pins),
      .rise_o (edges.rise),
      .fall_o (edges.fall)
   );

   spc_wdog_pulse #(
      .CYCLES (WDOG_CYC)
   ) u_wdog (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (watchdog_reset_i),
      .drive_o (wdog_drive)
   );

   // Struct order is fault_a, fault_b, user_one, user_two from bit 3 down.
   assign ev_one = pin_ctrl_q[spc_pkg::PC_POL_ONE] ? edges.rise[1] : edges.fall[1];
   assign ev_two = pin_ctrl_q[spc_pkg::PC_POL_TWO] ? edges.rise[0] : edges.fall[0];

   always_comb begin
      irq_event = '0;
      irq_event[spc_pkg::IRQ_FAULT_A]  = edges.fall[3];
      irq_event[spc_pkg::IRQ_FAULT_B]  = edges.fall[2];
      irq_event[spc_pkg::IRQ_USER_ONE] = ev_one;
      irq_event[spc_pkg::IRQ_USER_TWO] = ev_two;
      irq_event[spc_pkg::IRQ_WDOG]     = watchdog_reset_i;
   end

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i;
   assign pin_low = ~device_reset_pin_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            spc_pkg::ADDR_SYS_CTRL:   wb_dat_o <= {16'h0000, sys_ctrl_q};
            spc_pkg::ADDR_SYS_CTRL2:  wb_dat_o <= {16'h0000, sys_ctrl2_q};
            spc_pkg::ADDR_IRQ_STATUS: wb_dat_o <= 32'(irq_status_q);
            spc_pkg::ADDR_IRQ_MASK:   wb_dat_o <= 32'(irq_mask_q);
            spc_pkg::ADDR_PIN_CTRL:   wb_dat_o <= 32'(pin_ctrl_q);
            spc_pkg::ADDR_CORE_STAT:  wb_dat_o <= {28'h0000000, float_q, fault_b_q,
                                                   fault_a_q, ~branch_test_input_i};
            spc_pkg::ADDR_GPIO_DIR:   wb_dat_o <= 32'(gpio_dir_q);
            default:                  wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || pin_low) begin
         sys_ctrl_q <= spc_pkg::SYS_CTRL_RST;
         pin_ctrl_q <= 6'h00;
         irq_mask_q <= '0;
         gpio_dir_q <= '0;
      end else if (wb_wr) begin
         if (wb_adr_i == spc_pkg::ADDR_SYS_CTRL) begin
            if (wb_sel_i[0]) sys_ctrl_q[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) sys_ctrl_q[15:8] <= wb_dat_i[15:8];
         end
         if (wb_adr_i == spc_pkg::ADDR_PIN_CTRL && wb_sel_i[0]) begin
            pin_ctrl_q <= wb_dat_i[5:0];
         end
         if (wb_adr_i == spc_pkg::ADDR_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[spc_pkg::NUM_IRQ-1:0];
         end
         if (wb_adr_i == spc_pkg::ADDR_GPIO_DIR) begin
            for (int i = 0; i < GPIO_W; i++) begin
               if (wb_sel_i[i/8]) gpio_dir_q[i] <= wb_dat_i[i];
            end
         end
      end
   end

   // Sticky status: hardware set outranks a write-one clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_q <= '0;
      end else begin
         for (int i = 0; i < spc_pkg::NUM_IRQ; i++) begin
            if (irq_event[i]) begin
               irq_status_q[i] <= 1'b1;
            end else if (wb_wr && wb_adr_i == spc_pkg::ADDR_IRQ_STATUS &&
                         wb_sel_i[0] && wb_dat_i[i]) begin
               irq_status_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((irq_status_q | irq_event) & irq_mask_q);
      end
   end

   // PWM float latches hold until software clears them, so a fault stays safe
   // even if the fault line bounces back high.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_a_q <= 1'b0;
         fault_b_q <= 1'b0;
      end else begin
         if (edges.fall[3]) begin
            fault_a_q <= 1'b1;
         end else if (wb_wr && wb_adr_i == spc_pkg::ADDR_PIN_CTRL &&
                      wb_sel_i[0] && wb_dat_i[spc_pkg::PC_FAULT_A_CLR]) begin
            fault_a_q <= 1'b0;
         end
         if (edges.fall[2]) begin
            fault_b_q <= 1'b1;
         end else if (wb_wr && wb_adr_i == spc_pkg::ADDR_PIN_CTRL &&
                      wb_sel_i[0] && wb_dat_i[spc_pkg::PC_FAULT_B_CLR]) begin
            fault_b_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_manager_a_pwm_float_o <= 1'b1;
         event_manager_b_pwm_float_o <= 1'b1;
         converter_start_trigger_o   <= 1'b0;
      end else begin
         event_manager_a_pwm_float_o <= fault_a_q | edges.fall[3] | float_q;
         event_manager_b_pwm_float_o <= fault_b_q | edges.fall[2] | float_q;
         converter_start_trigger_o   <= ev_two;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         device_reset_pin_o      <= 1'b0;
         device_reset_pin_oe_n_o <= 1'b1;
      end else begin
         device_reset_pin_o      <= 1'b0;
         device_reset_pin_oe_n_o <= ~wdog_drive;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_halt_o            <= 1'b1;
         program_counter_o      <= spc_pkg::PROG_START;
         program_counter_load_o <= 1'b1;
      end else begin
         core_halt_o            <= pin_low;
         program_counter_o      <= spc_pkg::PROG_START;
         program_counter_load_o <= pin_low;
      end
   end

   // Boot strap is caught by a clocked sample while reset is asserted.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_strap_q <= boot_en_pin_i;
      end else if (pin_low) begin
         boot_strap_q <= boot_en_pin_i;
      end
   end

   assign sys_ctrl2_q = 16'(boot_strap_q) << spc_pkg::BOOT_EN_BIT;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_of_reset_q      <= 1'b0;
         external_flag_out_o <= 1'b1;
         boot_pin_oe_n_o     <= 1'b1;
      end else begin
         out_of_reset_q      <= ~pin_low;
         external_flag_out_o <= 1'b1;
         boot_pin_oe_n_o     <= ~(out_of_reset_q & ~pin_low) | float_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_out_pin_o <= 1'b0;
      end else if (pin_ctrl_q[spc_pkg::PC_CLK_GPIO]) begin
         clock_out_pin_o <= clock_gpio_out_i;
      end else begin
         clock_out_pin_o <= sys_ctrl_q[spc_pkg::CLK_SEL_BIT] ? watchdog_clock_i
                                                              : cpu_clock_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conditional_branch_take_o <= 1'b0;
         branch_pin_gpio_o         <= 1'b0;
      end else begin
         branch_pin_gpio_o         <= pin_ctrl_q[spc_pkg::PC_BR_GPIO];
         conditional_branch_take_o <= ~pin_ctrl_q[spc_pkg::PC_BR_GPIO] &
                                      ~branch_test_input_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_oe_n_o <= '1;
      end else begin
         gpio_oe_n_o <= ~gpio_dir_q | {GPIO_W{float_q}};
      end
   end

   // Float needs the other party to hold emulator zero high as well.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         float_q             <= 1'b0;
         all_outputs_float_o <= 1'b0;
         crystal_out_float_o <= 1'b0;
      end else begin
         float_q             <= ~test_reset_i & ~emulator_io_one_float_i &
                                emulator_io_zero_i;
         all_outputs_float_o <= float_q;
         crystal_out_float_o <= float_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emu_pin_o      <= 2'h0;
         emu_pin_oe_n_o <= 2'h3;
         emu_irq_in_o   <= 2'h0;
      end else begin
         emu_pin_o      <= emu_irq_out_i;
         emu_pin_oe_n_o <= test_reset_i ? ~emu_scan_dir_out_i : 2'h3;
         emu_irq_in_o   <= test_reset_i ? {emulator_io_one_float_i,
                                           emulator_io_zero_i} : 2'h0;
      end
   end
endmodule
`default_nettype wire

// [sim/spc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_props #(
   parameter int WDOG_CYC = 128
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic device_reset_pin_i,
   input wire logic device_reset_pin_o,
   input wire logic device_reset_pin_oe_n_o,
   input wire logic watchdog_reset_i,
   input wire logic core_halt_o,
   input wire logic drive_fault_in_a_i,
   input wire logic drive_fault_in_b_i,
   input wire logic event_manager_a_pwm_float_o,
   input wire logic event_manager_b_pwm_float_o,
   input wire logic converter_start_trigger_o,
   input wire logic external_flag_out_o,
   input wire logic test_reset_i,
   input wire logic emulator_io_zero_i,
   input wire logic emulator_io_one_float_i,
   input wire logic all_outputs_float_o,
   input wire logic crystal_out_float_o
);
   logic [8:0] low_q;
   logic       float_c;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign float_c = !test_reset_i && emulator_io_zero_i && !emulator_io_one_float_i;
   always_ff @(posedge clk_i) begin
      if (rst_i || device_reset_pin_oe_n_o) begin
         low_q <= 9'h000;
      end else begin
         low_q <= low_q + 9'h001;
      end
   end
   chk_wdog_len: assert property (
      $rose(device_reset_pin_oe_n_o) |-> 32'(low_q) == WDOG_CYC)
      else $error("bad reset pulse length");
   chk_wdog_start: assert property (
      $rose(watchdog_reset_i) && device_reset_pin_oe_n_o |-> ##[1:3] !device_reset_pin_oe_n_o)
      else $error("reset pin not pulled");
   chk_drain_only: assert property (!device_reset_pin_o)
      else $error("reset pin driven high");
   chk_halt_pin: assert property (!device_reset_pin_i [*3] |-> core_halt_o)
      else $error("core not halted");
   chk_run_pin: assert property (device_reset_pin_i [*3] |-> !core_halt_o)
      else $error("core halted");
   chk_fault_a_float: assert property (
      $fell(drive_fault_in_a_i) |-> ##[2:6] event_manager_a_pwm_float_o)
      else $error("fault a not floated");
   chk_fault_b_float: assert property (
      $fell(drive_fault_in_b_i) |-> ##[2:6] event_manager_b_pwm_float_o)
      else $error("fault b not floated");
   chk_trig_pulse: assert property (
      converter_start_trigger_o |=> !converter_start_trigger_o)
      else $error("trigger too long");
   chk_flag_high: assert property (external_flag_out_o)
      else $error("external flag not high");
   chk_float_on: assert property (
      float_c [*4] |-> all_outputs_float_o && crystal_out_float_o)
      else $error("outputs not floated");
   chk_float_off: assert property (
      !float_c [*4] |-> !all_outputs_float_o && !crystal_out_float_o)
      else $error("outputs floated wrongly");
   cov_wdog: cover property ($rose(device_reset_pin_oe_n_o));
   cov_fault: cover property ($fell(drive_fault_in_b_i));
   cov_float: cover property (all_outputs_float_o);
endmodule
bind spc_top spc_props #(.WDOG_CYC(WDOG_CYC)) props_u (.*);
`default_nettype wire

// [sim/spc_board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spc_board_model (
   input  wire logic       pin_drv_i,
   input  wire logic       pin_oe_n_i,
   input  wire logic       hold_low_i,
   input  wire logic       scan_i,
   input  wire logic       float_i,
   input  wire logic [1:0] emu_drv_i,
   input  wire logic [1:0] emu_oe_n_i,
   output logic            rst_pin_o,
   output logic            test_reset_o,
   output logic [1:0]      emu_o
);
   assign rst_pin_o = !((!pin_oe_n_i && !pin_drv_i) || hold_low_i);
   assign test_reset_o = scan_i && !float_i;
   assign emu_o[0] = !emu_oe_n_i[0] ? emu_drv_i[0] : 1'b1;
   assign emu_o[1] = !emu_oe_n_i[1] ? emu_drv_i[1] : !float_i;
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i, rst_i, wb_cyc, wb_we, ack, wd, fa, fb, u1, u2, irq, conv, flag, boot_oe;
   logic        cpu_ck, wd_ck, ck_gpio, boot, bt, hold, scan, flt, rp_o, rp_oe, rp, tr;
   logic        clk_o, take, br_gpio, halt, pc_ld, pwm_a, pwm_b, all_f, xtal_f;
   logic [1:0]  emu, emu_dir, emu_irq, emu_o, emu_oe, emu_in;
   logic [7:0]  adr;
   logic [15:0] pc, gpio_oe;
   logic [31:0] wdat, rdat, rd;
   int          error_cnt, comparisons, conv_cnt;
   spc_top #(.GPIO_W(16), .WDOG_CYC(128)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .device_reset_pin_i(rp), .device_reset_pin_o(rp_o),
      .device_reset_pin_oe_n_o(rp_oe), .watchdog_reset_i(wd), .core_halt_o(halt),
      .program_counter_o(pc), .program_counter_load_o(pc_ld), .drive_fault_in_a_i(fa),
      .drive_fault_in_b_i(fb), .user_irq_one_i(u1), .user_irq_two_i(u2),
      .event_manager_a_pwm_float_o(pwm_a), .event_manager_b_pwm_float_o(pwm_b),
      .converter_start_trigger_o(conv), .cpu_clock_i(cpu_ck), .watchdog_clock_i(wd_ck),
      .clock_gpio_out_i(ck_gpio), .clock_out_pin_o(clk_o), .boot_en_pin_i(boot),
      .external_flag_out_o(flag), .boot_pin_oe_n_o(boot_oe), .branch_test_input_i(bt),
      .conditional_branch_take_o(take), .branch_pin_gpio_o(br_gpio), .gpio_oe_n_o(gpio_oe),
      .test_reset_i(tr), .emulator_io_zero_i(emu[0]), .emulator_io_one_float_i(emu[1]),
      .emu_scan_dir_out_i(emu_dir), .emu_irq_out_i(emu_irq), .emu_pin_o(emu_o),
      .emu_pin_oe_n_o(emu_oe), .emu_irq_in_o(emu_in), .all_outputs_float_o(all_f),
      .crystal_out_float_o(xtal_f));
   spc_board_model board_u (.pin_drv_i(rp_o), .pin_oe_n_i(rp_oe), .hold_low_i(hold),
      .scan_i(scan), .float_i(flt), .emu_drv_i(emu_o), .emu_oe_n_i(emu_oe),
      .rst_pin_o(rp), .test_reset_o(tr), .emu_o(emu));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (conv === 1'b1) conv_cnt++;
   task automatic tally_and_finish();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rdat;
      wb_cyc <= 1'b0;
      if (n >= 20) begin
         check("wb_ack", ack, 32'h1);
         tally_and_finish();
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      check(n, rd & m, e);
   endtask
   task automatic t_reset();
      @(posedge clk_i);
      check("gpio_oe_n", gpio_oe, 32'hffff);
      check("pc", {br_gpio, pc}, 32'h0);
      wb(spc_pkg::ADDR_SYS_CTRL2, 1'b1, 32'h0);
      rchk("boot_strap", spc_pkg::ADDR_SYS_CTRL2, 32'h8, 32'h8);
      rchk("gpio_dir", spc_pkg::ADDR_GPIO_DIR, 32'hffff, 32'h0);
      rchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
      check("flag", {flag, boot_oe}, 32'h2);
   endtask
   task automatic t_pin();
      boot <= 1'b0;
      hold <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("halt", {halt, pc_ld, pc}, 32'h30000);
      hold <= 1'b0;
      repeat (4) @(posedge clk_i);
      check("run", {halt, pc_ld}, 32'h0);
      boot <= 1'b1;
      rchk("boot_resample", spc_pkg::ADDR_SYS_CTRL2, 32'h8, 32'h0);
   endtask
   task automatic t_wdog();
      int n, lo;
      @(posedge clk_i);
      wd <= 1'b1;
      @(posedge clk_i);
      wd <= 1'b0;
      n = 0;
      while (rp !== 1'b0 && n < 10) begin
         @(posedge clk_i);
         n++;
      end
      lo = 0;
      while (rp === 1'b0 && lo < 300) begin
         @(posedge clk_i);
         lo++;
         wd <= (lo == 20);
      end
      check("wdog_low", lo, 32'h80);
      check("pin_level", rp_o, 32'h0);
   endtask
   task automatic t_fault();
      for (int i = 0; i < 2; i++) begin
         wb(spc_pkg::ADDR_IRQ_MASK, 1'b1, 32'h1 << i);
         if (i == 0) fa <= 1'b0;
         else fb <= 1'b0;
         repeat (6) @(posedge clk_i);
         check("fault", {pwm_b, pwm_a, irq}, {i[0], ~i[0], 1'b1});
         rchk("fault_stat", spc_pkg::ADDR_IRQ_STATUS, 32'h3, 32'h1 << i);
         wb(spc_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0);
         repeat (2) @(posedge clk_i);
         check("masked_irq", irq, 32'h0);
         wb(spc_pkg::ADDR_IRQ_STATUS, 1'b1, 32'h1 << i);
         wb(spc_pkg::ADDR_PIN_CTRL, 1'b1, 32'h10 << i);
         {fa, fb} <= 2'b11;
         repeat (6) @(posedge clk_i);
         rchk("rise_ignored", spc_pkg::ADDR_IRQ_STATUS, 32'h3, 32'h0);
         check("pwm_clear", {pwm_b, pwm_a}, 32'h0);
      end
   endtask
   task automatic t_user();
      int c;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 2; i++) begin
            wb(spc_pkg::ADDR_PIN_CTRL, 1'b1, p ? 32'h3 : 32'h0);
            c = conv_cnt;
            if (i == 0) u1 <= 1'b0;
            else u2 <= 1'b0;
            repeat (6) @(posedge clk_i);
            rchk("edge_one", spc_pkg::ADDR_IRQ_STATUS, 32'hc, p ? 32'h0 : 32'h4 << i);
            {u1, u2} <= 2'b11;
            repeat (6) @(posedge clk_i);
            rchk("edge_two", spc_pkg::ADDR_IRQ_STATUS, 32'hc, 32'h4 << i);
            check("conv_pulses", conv_cnt - c, i);
            wb(spc_pkg::ADDR_IRQ_STATUS, 1'b1, 32'hc);
         end
      end
   endtask
   task automatic t_clk_branch();
      {cpu_ck, wd_ck, ck_gpio} <= 3'b101;
      for (int k = 0; k < 3; k++) begin
         wb(spc_pkg::ADDR_SYS_CTRL, 1'b1, k ? 32'h4000 : 32'h0);
         wb(spc_pkg::ADDR_PIN_CTRL, 1'b1, (k == 2) ? 32'hc : 32'h0);
         bt <= k[0];
         repeat (3) @(posedge clk_i);
         check("clock_out", clk_o, (k == 1) ? 32'h0 : 32'h1);
         check("branch", {br_gpio, take}, 32'({k[1], k == 0}));
      end
      hold <= 1'b1;
      repeat (4) @(posedge clk_i);
      hold <= 1'b0;
      repeat (4) @(posedge clk_i);
      check("branch_reset", br_gpio, 32'h0);
   endtask
   task automatic t_float_emu();
      flt <= 1'b1;
      repeat (5) @(posedge clk_i);
      check("float", {all_f, xtal_f, pwm_a, pwm_b}, 32'hf);
      flt <= 1'b0;
      repeat (5) @(posedge clk_i);
      check("unfloat", {all_f, xtal_f}, 32'h0);
      {scan, emu_dir, emu_irq} <= 5'b10100;
      repeat (4) @(posedge clk_i);
      check("emu_dir", {emu_oe, emu_o[0], emu_in[1]}, 32'h9);
      scan <= 1'b0;
   endtask
   initial begin
      {wb_cyc, wb_we, wd, hold, scan, flt, cpu_ck, wd_ck, ck_gpio, bt} = 10'h000;
      {fa, fb, u1, u2, boot} = 5'h1f;
      {adr, wdat, emu_dir, emu_irq} = 44'h0;
      {error_cnt, comparisons, conv_cnt} = 96'h0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_pin();
      t_wdog();
      t_fault();
      t_user();
      t_clk_branch();
      t_float_emu();
      tally_and_finish();
   end
endmodule
`default_nettype wire
